/* File: dv/general_timer_oneshot_continuous_tb.sv */
`timescale 1ns/1ps
`include "gtm_defines.svh"
// ********************
// timer bench
// ********************
module general_timer_oneshot_continuous_tb;
    import gtm_pkg::*;
    logic aclk = 0;
    logic aresetn = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic timer_in, timer_out, irq, irq_event;
    logic [15:0] cnt_mirror;
    int failures = 0;
    int n_checks = 0;
    int c;
    // 25 MHz system clock
    always #20 aclk = ~aclk;
    gtm_timer u_gtm_timer (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .timer_in(timer_in),
        .unused_cnt_mirror(cnt_mirror), .timer_out(timer_out), .irq(irq),
        .irq_event(irq_event));
    gtm_pin_model u_gtm_pin_model (.aclk(aclk), .timer_in(timer_in));
    task end_of_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic hang(input string s);
        chk(s, 32'h1, 32'h0);
        end_of_test;
    endtask
    // both write channels offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v,
                      input logic [1:0] er);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
        end while (bvalid !== 1'b1 && n < 50);
        bready <= 0;
        if (n >= 50) hang("bvalid wait");
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v,
                      input logic [1:0] er);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 0;
        end while (rvalid !== 1'b1 && n < 50);
        v = rdata;
        rready <= 0;
        if (n >= 50) hang("rvalid wait");
        chk("rresp", {30'h0, er}, {30'h0, rresp});
    endtask
    // counts falling edges until the reload event or the limit
    task automatic ev_wait(input int lim, output int n);
        n = 0;
        do begin
            @(negedge aclk);
            n++;
        end while (irq_event !== 1'b1 && n < lim);
    endtask
    task t_regs;
        rd(`GTM_OFS_CTRL, d, 2'b00);
        chk("ctrl reset", 0, d);
        rd(`GTM_OFS_COUNT, d, 2'b00);
        chk("count reset", 1, d);
        rd(`GTM_OFS_RELOAD, d, 2'b00);
        chk("reload reset", 0, d);
        rd(8'h14, d, 2'b10);
        chk("unmapped rdata", 0, d);
        wr(8'h14, 32'h1, 2'b10);
        // the reserved mode must not start the machine
        wr(`GTM_OFS_CTRL, 32'h7, 2'b00);
        repeat (3) @(negedge aclk);
        rd(`GTM_OFS_STATUS, d, 2'b00);
        chk("mode3 idle", 0, d[2:1]);
        wr(`GTM_OFS_CTRL, 32'h0, 2'b00);
        $display("test regs done");
    endtask
    task t_oneshot;
        wr(`GTM_OFS_CTRL, 32'h30, 2'b00);
        wr(`GTM_OFS_COUNT, 32'h2, 2'b00);
        wr(`GTM_OFS_RELOAD, 32'h5, 2'b00);
        wr(`GTM_OFS_MASK, 32'h0, 2'b00);
        wr(`GTM_OFS_CTRL, 32'h31, 2'b00);
        ev_wait(40, c);
        chk("os time", 1, c >= 8 && c <= 12);
        chk("os pulse", 1, timer_out);
        @(negedge aclk);
        chk("os back", 0, timer_out);
        rd(`GTM_OFS_CTRL, d, 2'b00);
        chk("os enable", 0, d[0]);
        rd(`GTM_OFS_COUNT, d, 2'b00);
        chk("os count", 1, d);
        chk("count mirror", 1, cnt_mirror);
        ev_wait(30, c);
        chk("os stopped", 0, irq_event);
        rd(`GTM_OFS_STATUS, d, 2'b00);
        chk("event bit", 1, d[0]);
        chk("irq masked", 0, irq);
        wr(`GTM_OFS_MASK, 32'h1, 2'b00);
        repeat (3) @(negedge aclk);
        chk("irq on", 1, irq);
        wr(`GTM_OFS_STATUS, 32'h1, 2'b00);
        repeat (3) @(negedge aclk);
        chk("irq cleared", 0, irq);
        // start low, then flip polarity while running for a lasting high
        wr(`GTM_OFS_CTRL, 32'h31, 2'b00);
        wr(`GTM_OFS_CTRL, 32'h39, 2'b00);
        ev_wait(40, c);
        chk("lasting pulse", 0, timer_out);
        @(negedge aclk);
        chk("lasting level", 1, timer_out);
        $display("test oneshot done");
    endtask
    task automatic t_cont(input int ps, st, rl);
        int e1;
        e1 = (rl - st + 1) & 32'hffff;
        if (e1 == 0) e1 = 65536;
        e1 = e1 << ps;
        wr(`GTM_OFS_CTRL, 32'h14 | (ps << 5), 2'b00);
        wr(`GTM_OFS_COUNT, st, 2'b00);
        wr(`GTM_OFS_RELOAD, rl, 2'b00);
        wr(`GTM_OFS_CTRL, 32'h15 | (ps << 5), 2'b00);
        ev_wait(e1 + 20, c);
        chk("first pass", 1, c >= e1 && c <= e1 + 6);
        chk("out toggled", 1, timer_out);
        ev_wait((rl << ps) + 20, c);
        chk("period", rl << ps, c);
        chk("out back", 0, timer_out);
        rd(`GTM_OFS_CTRL, d, 2'b00);
        chk("still enabled", 1, d[0]);
        wr(`GTM_OFS_CTRL, 32'h0, 2'b00);
        $display("test continuous done");
    endtask
    task automatic t_trig(input logic p);
        wr(`GTM_OFS_CTRL, 32'h12 | (p << 3), 2'b00);
        u_gtm_pin_model.level(p);
        wr(`GTM_OFS_COUNT, 32'h1, 2'b00);
        wr(`GTM_OFS_RELOAD, 32'd20, 2'b00);
        wr(`GTM_OFS_CTRL, 32'h13 | (p << 3), 2'b00);
        ev_wait(30, c);
        chk("armed only", 0, irq_event);
        rd(`GTM_OFS_STATUS, d, 2'b00);
        chk("armed flag", 1, d[1]);
        u_gtm_pin_model.level(!p);
        repeat (4) @(posedge aclk);
        u_gtm_pin_model.level(p);
        u_gtm_pin_model.level(!p);
        // a restart on the late edge would push the event out
        ev_wait(40, c);
        chk("late edge ignored", 1, c >= 14 && c <= 18);
        chk("pulse level", !p, timer_out);
        ev_wait(40, c);
        chk("single event", 0, irq_event);
        u_gtm_pin_model.level(p);
        u_gtm_pin_model.level(!p);
        ev_wait(40, c);
        chk("trigger delay", 1, c >= 21 && c <= 25);
        wr(`GTM_OFS_CTRL, 32'h0, 2'b00);
        $display("test triggered done");
    endtask
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        t_regs;
        t_oneshot;
        t_cont(0, 5, 4);
        t_cont(7, 1, 2);
        t_trig(1'b0);
        t_trig(1'b1);
        end_of_test;
    end
endmodule

/* File: dv/gtm_pin_model.sv */
`timescale 1ns/1ps
// ********************
// trigger pin driver
// ********************
module gtm_pin_model (
    // clock
    input wire logic aclk,
    // trigger pin
    output logic timer_in
);
    initial timer_in = 1'b0;
    // move the pin just after an edge, never on the sampling edge itself
    task automatic level(input logic v);
        @(posedge aclk);
        timer_in <= v;
    endtask
endmodule

/* File: src/gtm_axil_slave.sv */
`timescale 1ns/1ps
`include "gtm_defines.svh"
module gtm_axil_slave (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write channels
    input wire logic [`GTM_AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [`GTM_DW-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // read channels
    input wire logic [`GTM_AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [`GTM_DW-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // register side
    gtm_reg_if.slave bus
);
    logic rd_pend;

    // ****************************************
    // write path
    // ****************************************
    // address and data are taken in either order; the write fires
    // once both are held, and both readies return after the response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= `GTM_RESP_OK;
            bus.wr_en <= 1'b0;
            bus.wr_addr <= '0;
            bus.wr_data <= '0;
            bus.wr_strb <= '0;
        end else begin
            bus.wr_en <= 1'b0;
            if (awvalid && awready) begin
                awready <= 1'b0;
                bus.wr_addr <= awaddr;
            end
            if (wvalid && wready) begin
                wready <= 1'b0;
                bus.wr_data <= wdata;
                bus.wr_strb <= wstrb;
            end
            if (!awready && !wready && !bvalid && !bus.wr_en) begin
                bus.wr_en <= 1'b1;
            end
            if (bus.wr_en) begin
                bvalid <= 1'b1;
                bresp <= bus.wr_ok ? `GTM_RESP_OK : `GTM_RESP_ERR;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // ****************************************
    // read path
    // ****************************************
    // the data is sampled one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= `GTM_RESP_OK;
            rd_pend <= 1'b0;
            bus.rd_addr <= '0;
        end else begin
            rd_pend <= 1'b0;
            if (arvalid && arready) begin
                arready <= 1'b0;
                bus.rd_addr <= araddr;
                rd_pend <= 1'b1;
            end
            if (rd_pend) begin
                rvalid <= 1'b1;
                rdata <= bus.rd_ok ? bus.rd_data : '0;
                rresp <= bus.rd_ok ? `GTM_RESP_OK : `GTM_RESP_ERR;
            end
            if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end
endmodule

/* File: src/gtm_defines.svh */
`ifndef GTM_DEFINES_SVH
`define GTM_DEFINES_SVH
// bus geometry
`define GTM_AW 8
`define GTM_DW 32
// register byte offsets
`define GTM_OFS_CTRL 8'h00
`define GTM_OFS_COUNT 8'h04
`define GTM_OFS_RELOAD 8'h08
`define GTM_OFS_STATUS 8'h0c
`define GTM_OFS_MASK 8'h10
// control fields
`define GTM_CTRL_EN 0
`define GTM_CTRL_MODE_LO 1
`define GTM_CTRL_POL 3
`define GTM_CTRL_OE 4
`define GTM_CTRL_PS_LO 5
// status fields
`define GTM_ST_EVT 0
`define GTM_ST_ARMED 1
`define GTM_ST_RUN 2
`define GTM_ST_OUT 3
// reset and restart values
`define GTM_RST_CTRL 8'h00
`define GTM_RST_COUNT 16'h0001
`define GTM_RST_RELOAD 16'h0000
`define GTM_COUNT_RESTART 16'h0001
// axi responses
`define GTM_RESP_OK 2'b00
`define GTM_RESP_ERR 2'b10
`endif

/* File: src/gtm_pkg.sv */
package gtm_pkg;
    typedef enum logic [1:0] {
        GTM_ONESHOT = 2'h0,
        GTM_TRIG = 2'h1,
        GTM_CONT = 2'h2,
        GTM_RSVD = 2'h3
    } gtm_mode_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_WAIT = 3'h2,
        ST_RUN = 3'h4
    } gtm_state_t;
    typedef logic [15:0] gtm_cnt_t;
endpackage

/* File: src/gtm_reg_if.sv */
`timescale 1ns/1ps
`include "gtm_defines.svh"
interface gtm_reg_if;
    logic wr_en;
    logic [`GTM_AW-1:0] wr_addr;
    logic [`GTM_DW-1:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_ok;
    logic [`GTM_AW-1:0] rd_addr;
    logic [`GTM_DW-1:0] rd_data;
    logic rd_ok;
    modport slave (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                   input wr_ok, rd_data, rd_ok);
    modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                  output wr_ok, rd_data, rd_ok);
endinterface

/* File: src/gtm_timer.sv */
`timescale 1ns/1ps
`include "gtm_defines.svh"
// Behaviour
// - one-shot counts prescaled ticks upward until count equals reload
// - one-shot reload: interrupt, count to 0001h, clear enable, stop
// - one-shot with output on: output inverted one clock at reload
// - one-shot timeout is (reload - start + 1) times prescale clocks
// - triggered mode waits for polarity-selected edge on input pin
// - after trigger, count prescaled ticks up to reload
// - triggered reload: one-clock output pulse, interrupt, count 0001h
// - then wait for next trigger; edges while counting are ignored
// - in triggered mode enable only arms the timer
// - trigger passes a two-stage synchroniser, 2-3 clocks extra
// - continuous reload: interrupt, count 0001h, keep counting
// - continuous with output on: toggle output on every reload
// - written start count applies only to first continuous pass
// - continuous period is reload times prescale clocks
// - prescaler divides the clock by 1 to 128
// - reload below count: count wraps through FFFFh to 0000h
module gtm_timer (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [`GTM_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [`GTM_DW-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [`GTM_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [`GTM_DW-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // timer pins
    input wire logic timer_in,
    output gtm_pkg::gtm_cnt_t unused_cnt_mirror,
    output logic timer_out,
    // interrupt
    output logic irq,
    output logic irq_event
);
    import gtm_pkg::*;

    gtm_reg_if rif();

    // ****************************************
    // state and registers
    // ****************************************
    logic enable;
    gtm_mode_t mode;
    logic pol;
    logic out_en;
    logic [2:0] presc;
    gtm_cnt_t count;
    gtm_cnt_t reload;
    logic evt_st;
    logic evt_mask;
    gtm_state_t state;
    gtm_state_t next_state;
    logic [6:0] pre_cnt;
    logic tin_s1;
    logic tin_s2;
    logic tin_s3;
    logic trig_edge;
    logic tick;
    logic hit;
    logic wr_ctrl;
    logic wr_cnt;
    logic next_tout;
    logic [7:0] ctrl_rst;
    logic [7:0] ctrl_new;

    // ****************************************
    // helpers
    // ****************************************
    // byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // prescale code n divides by 2**n, so the divider limit is 2**n - 1
    function automatic logic [6:0] limit(input logic [2:0] code);
        logic [7:0] p;
        p = 8'h01 << code;
        return 7'(p - 8'h01);
    endfunction

    function automatic logic hit_addr(input logic [`GTM_AW-1:0] a,
                                      input logic [`GTM_AW-1:0] o);
        return a == o;
    endfunction

    gtm_axil_slave u_slave (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(s_axi_awaddr),
        .awvalid(s_axi_awvalid),
        .awready(s_axi_awready),
        .wdata(s_axi_wdata),
        .wstrb(s_axi_wstrb),
        .wvalid(s_axi_wvalid),
        .wready(s_axi_wready),
        .bresp(s_axi_bresp),
        .bvalid(s_axi_bvalid),
        .bready(s_axi_bready),
        .araddr(s_axi_araddr),
        .arvalid(s_axi_arvalid),
        .arready(s_axi_arready),
        .rdata(s_axi_rdata),
        .rresp(s_axi_rresp),
        .rvalid(s_axi_rvalid),
        .rready(s_axi_rready),
        .bus(rif.slave)
    );

    // ****************************************
    // register decode
    // ****************************************
    assign wr_ctrl = rif.wr_en && hit_addr(rif.wr_addr, `GTM_OFS_CTRL);
    assign wr_cnt = rif.wr_en && hit_addr(rif.wr_addr, `GTM_OFS_COUNT);

    // unmapped offsets answer with an error response
    always_comb begin
        rif.wr_ok = 1'b1;
        case (rif.wr_addr)
            `GTM_OFS_CTRL, `GTM_OFS_COUNT, `GTM_OFS_RELOAD,
            `GTM_OFS_STATUS, `GTM_OFS_MASK: rif.wr_ok = 1'b1;
            default: rif.wr_ok = 1'b0;
        endcase
    end

    // read mux; status shows live state of the machine
    always_comb begin
        rif.rd_ok = 1'b1;
        rif.rd_data = '0;
        case (rif.rd_addr)
            `GTM_OFS_CTRL: rif.rd_data[7:0] =
                {presc, out_en, pol, mode, enable};
            `GTM_OFS_COUNT: rif.rd_data[15:0] = count;
            `GTM_OFS_RELOAD: rif.rd_data[15:0] = reload;
            `GTM_OFS_STATUS: rif.rd_data[3:0] =
                {timer_out, state == ST_RUN, state == ST_WAIT, evt_st};
            `GTM_OFS_MASK: rif.rd_data[0] = evt_mask;
            default: rif.rd_ok = 1'b0;
        endcase
    end

    // ****************************************
    // control register
    // ****************************************
    // fields are split out so the mode enum is only written through a cast
    assign ctrl_rst = `GTM_RST_CTRL;
    assign ctrl_new = 8'(merge(32'({presc, out_en, pol, mode, enable}),
                               rif.wr_data, rif.wr_strb));

    // a software write wins over the hardware self-clear; software is
    // expected to disable first and set up before enabling again
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            presc <= ctrl_rst[7:5];
            out_en <= ctrl_rst[4];
            pol <= ctrl_rst[3];
            mode <= gtm_mode_t'(ctrl_rst[2:1]);
            enable <= ctrl_rst[0];
        end else if (wr_ctrl) begin
            presc <= ctrl_new[7:5];
            out_en <= ctrl_new[4];
            pol <= ctrl_new[3];
            mode <= gtm_mode_t'(ctrl_new[2:1]);
            enable <= ctrl_new[0];
        end else if (hit && mode == GTM_ONESHOT) begin
            enable <= 1'b0;
        end
    end

    // reload value and interrupt mask
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reload <= `GTM_RST_RELOAD;
            evt_mask <= 1'b0;
        end else if (rif.wr_en) begin
            if (hit_addr(rif.wr_addr, `GTM_OFS_RELOAD)) begin
                reload <= 16'(merge(32'(reload), rif.wr_data,
                                    rif.wr_strb));
            end
            if (hit_addr(rif.wr_addr, `GTM_OFS_MASK) && rif.wr_strb[0]) begin
                evt_mask <= rif.wr_data[`GTM_ST_EVT];
            end
        end
    end

    // ****************************************
    // trigger input synchroniser
    // ****************************************
    // two stages before any logic; the third stage feeds the edge test
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tin_s1 <= 1'b0;
            tin_s2 <= 1'b0;
            tin_s3 <= 1'b0;
        end else begin
            tin_s1 <= timer_in;
            tin_s2 <= tin_s1;
            tin_s3 <= tin_s2;
        end
    end

    // polarity low selects rising edges, high selects falling
    assign trig_edge = pol ? (tin_s3 && !tin_s2) : (!tin_s3 && tin_s2);

    // ****************************************
    // sequencing
    // ****************************************
    // a software disable returns to idle from any state
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (enable && mode == GTM_TRIG) begin
                    next_state = ST_WAIT;
                end else if (enable && mode != GTM_RSVD) begin
                    next_state = ST_RUN;
                end
            end
            ST_WAIT: begin
                if (!enable) begin
                    next_state = ST_IDLE;
                end else if (trig_edge) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!enable) begin
                    next_state = ST_IDLE;
                end else if (hit && mode == GTM_ONESHOT) begin
                    next_state = ST_IDLE;
                end else if (hit && mode == GTM_TRIG) begin
                    next_state = ST_WAIT;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************
    // prescaler and counter
    // ****************************************
    // the divider restarts whenever counting is not under way
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_cnt <= '0;
        end else if (state != ST_RUN || tick) begin
            pre_cnt <= '0;
        end else begin
            pre_cnt <= pre_cnt + 7'h01;
        end
    end

    assign tick = state == ST_RUN && pre_cnt == limit(presc);
    // compare on every tick; trigger edges while running are unused
    assign hit = tick && count == reload;

    // a written start count only lasts until the first reload
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= `GTM_RST_COUNT;
        end else if (wr_cnt) begin
            count <= 16'(merge(32'(count), rif.wr_data, rif.wr_strb));
        end else if (hit) begin
            count <= `GTM_COUNT_RESTART;
        end else if (tick) begin
            count <= count + 16'h0001;
        end
    end

    // ****************************************
    // timer output
    // ****************************************
    // one-shot modes invert for one clock; continuous toggles and
    // otherwise rests at the polarity level
    always_comb begin
        if (!out_en) begin
            next_tout = pol;
        end else if (mode == GTM_CONT) begin
            if (state != ST_RUN) begin
                next_tout = pol;
            end else begin
                next_tout = timer_out ^ hit;
            end
        end else begin
            next_tout = pol ^ hit;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_out <= 1'b0;
        end else begin
            timer_out <= next_tout;
        end
    end

    // ****************************************
    // interrupt
    // ****************************************
    // set wins over a write-one clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_st <= 1'b0;
            irq_event <= 1'b0;
            irq <= 1'b0;
        end else begin
            irq_event <= hit;
            if (hit) begin
                evt_st <= 1'b1;
            end else if (rif.wr_en && rif.wr_strb[0] &&
                         hit_addr(rif.wr_addr, `GTM_OFS_STATUS) &&
                         rif.wr_data[`GTM_ST_EVT]) begin
                evt_st <= 1'b0;
            end
            irq <= (evt_st || hit) && evt_mask;
        end
    end

    // count mirror for observation pins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            unused_cnt_mirror <= `GTM_RST_COUNT;
        end else begin
            unused_cnt_mirror <= count;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    property p_step;
        @(posedge aclk) disable iff (!aresetn)
        tick && !hit && !wr_cnt |=> count == $past(count) + 16'h0001;
    endproperty
    a_step: assert property (p_step)
        else $error("count did not advance on tick");

    property p_restart;
        @(posedge aclk) disable iff (!aresetn)
        hit && !wr_cnt |=> count == 16'h0001 && irq_event;
    endproperty
    a_restart: assert property (p_restart)
        else $error("reload did not restart count");

    property p_os_stop;
        @(posedge aclk) disable iff (!aresetn)
        hit && mode == GTM_ONESHOT && !wr_ctrl |=>
            !enable && state == ST_IDLE;
    endproperty
    a_os_stop: assert property (p_os_stop)
        else $error("one-shot did not stop");

    property p_os_pulse;
        @(posedge aclk) disable iff (!aresetn)
        hit && out_en && mode != GTM_CONT && !wr_ctrl |=>
            timer_out != pol ##1 (timer_out == $past(pol) || wr_ctrl);
    endproperty
    a_os_pulse: assert property (p_os_pulse)
        else $error("one-shot pulse wrong");

    property p_armed;
        @(posedge aclk) disable iff (!aresetn)
        state == ST_WAIT && !wr_cnt |=> count == $past(count);
    endproperty
    a_armed: assert property (p_armed)
        else $error("counted while armed");

    property p_trig_go;
        @(posedge aclk) disable iff (!aresetn)
        state == ST_WAIT && enable && trig_edge |=> state == ST_RUN;
    endproperty
    a_trig_go: assert property (p_trig_go)
        else $error("trigger edge not taken");

    property p_trig_back;
        @(posedge aclk) disable iff (!aresetn)
        hit && mode == GTM_TRIG && enable && !wr_ctrl |=>
            state == ST_WAIT;
    endproperty
    a_trig_back: assert property (p_trig_back)
        else $error("no return to wait after trigger shot");

    property p_cont_tog;
        @(posedge aclk) disable iff (!aresetn)
        hit && out_en && mode == GTM_CONT && enable && !wr_ctrl |=>
            timer_out != $past(timer_out) && state == ST_RUN;
    endproperty
    a_cont_tog: assert property (p_cont_tog)
        else $error("continuous output did not toggle");

    property p_presc;
        @(posedge aclk) disable iff (!aresetn)
        tick && presc != 3'h0 && !wr_ctrl |=> !tick;
    endproperty
    a_presc: assert property (p_presc)
        else $error("prescaler ticked twice");

    property p_sync;
        @(posedge aclk) disable iff (!aresetn)
        trig_edge && !pol |-> $past(timer_in, 2) && !$past(timer_in, 3);
    endproperty
    a_sync: assert property (p_sync)
        else $error("trigger not synchronised");

    c_oneshot: cover property (@(posedge aclk) disable iff (!aresetn)
        hit && mode == GTM_ONESHOT);
    c_trig: cover property (@(posedge aclk) disable iff (!aresetn)
        state == ST_WAIT ##1 state == ST_RUN ##[1:50] hit);
    c_cont: cover property (@(posedge aclk) disable iff (!aresetn)
        hit && mode == GTM_CONT ##[1:50] hit);
endmodule
